// [inc/cfo_map.vh]
`ifndef CFO_MAP_VH
`define CFO_MAP_VH

// ********************************************************
// Register byte addresses.
// ********************************************************
`define CFO_A_FLAGS 12'h000
`define CFO_A_PC 12'h004
`define CFO_A_OPND 12'h008
`define CFO_A_STAT 12'h00C

// ********************************************************
// Flag bit positions and fixed values.
// ********************************************************
`define CFO_B_V 7
`define CFO_B_H 4
`define CFO_B_I 3
`define CFO_B_N 2
`define CFO_B_Z 1
`define CFO_B_C 0
`define CFO_FIX1 8'h60
`define CFO_FLAGS_RST 8'h68
`define CFO_PC_RST 16'h0000

// ********************************************************
// ALU operation codes.
// ********************************************************
`define CFO_OP_ADD 4'h0
`define CFO_OP_ADC 4'h1
`define CFO_OP_SUB 4'h2
`define CFO_OP_SBC 4'h3
`define CFO_OP_AND 4'h4
`define CFO_OP_ORA 4'h5
`define CFO_OP_EOR 4'h6
`define CFO_OP_LD8 4'h7
`define CFO_OP_LD16 4'h8
`define CFO_OP_DADJ 4'h9
`define CFO_OP_ASL 4'hA
`define CFO_OP_LSR 4'hB
`define CFO_OP_ROL 4'hC
`define CFO_OP_BTST 4'hD
`define CFO_OP_TAP 4'hE
`define CFO_OP_CLM 4'hF

// ********************************************************
// Operand modes and decimal-adjust constants.
// ********************************************************
`define CFO_M_INHERENT 2'h0
`define CFO_M_IMMED8 2'h1
`define CFO_M_IMMED16 2'h2
`define CFO_M_RELATIVE 2'h3
`define CFO_BCD_NIB 4'h9
`define CFO_BCD_BYTE 8'h99
`define CFO_BCD_LO 8'h06
`define CFO_BCD_HI 8'h60

`endif

// [logic/cfo_core.v]
`timescale 1ns/1ns
`include "cfo_map.vh"

module cfo_core (
    input wire CLK_IN,
    input wire RST_B_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output reg PREADY_OUT,
    output reg PSLVERR_OUT,
    input wire OP_VALID_IN,
    input wire [3:0] OP_CODE_IN,
    input wire [7:0] OP_A_IN,
    input wire [7:0] OP_B_IN,
    output reg [7:0] RESULT_OUT,
    output reg [7:0] FLAGS_OUT,
    output reg LESS_OUT,
    output reg LESS_EQ_OUT,
    input wire STACKED_IN,
    input wire BOUNDARY_IN,
    input wire INT_REQ_IN,
    output reg INT_TAKE_OUT,
    input wire FETCH_IN,
    input wire [1:0] MODE_IN,
    input wire COND_IN,
    output reg [15:0] MEM_ADDR_OUT,
    output reg MEM_RD_OUT,
    input wire [7:0] MEM_RDATA_IN,
    output reg [15:0] OPND_OUT,
    output reg DONE_OUT,
    output reg BUSY_OUT
);

    // ********************************************************
    // State codes.
    // ********************************************************
    localparam S_IDLE = 3'h0;
    localparam S_RD1 = 3'h1;
    localparam S_CAP1 = 3'h2;
    localparam S_RD2 = 3'h3;
    localparam S_CAP2 = 3'h4;

    // ********************************************************
    // Functions.
    // ********************************************************
    function [8:0] add8;
        input [7:0] a;
        input [7:0] b;
        input ci;
        add8 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    endfunction

    function [15:0] sext8;
        input [7:0] v;
        sext8 = {{8{v[7]}}, v};
    endfunction

    // ********************************************************
    // Flag unit.
    // ********************************************************
    reg [7:0] flags_r;
    reg [7:0] flags_nxt;
    reg [7:0] res_nxt;
    reg [8:0] sum;
    reg [7:0] cor;
    reg blk_r;
    reg blk_nxt;
    reg nz_upd;
    reg [7:0] fsel;

    wire apb_setup = PSEL_IN & ~PENABLE_IN;
    wire apb_wr = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN & ~PSLVERR_OUT;

    always @* begin
        fsel = flags_r;
        if (apb_wr && PADDR_IN == `CFO_A_FLAGS)
            fsel = PWDATA_IN[7:0];
        flags_nxt = fsel;
        res_nxt = RESULT_OUT;
        sum = 9'h000;
        cor = 8'h00;
        nz_upd = 1'b0;
        blk_nxt = blk_r;
        if (BOUNDARY_IN)
            blk_nxt = 1'b0;
        if (OP_VALID_IN) begin
            flags_nxt = flags_r;
            nz_upd = 1'b1;
            case (OP_CODE_IN)
                `CFO_OP_ADD, `CFO_OP_ADC: begin
                    sum = add8(OP_A_IN, OP_B_IN,
                        (OP_CODE_IN == `CFO_OP_ADC) & flags_r[`CFO_B_C]);
                    res_nxt = sum[7:0];
                    flags_nxt[`CFO_B_H] = OP_A_IN[4] ^ OP_B_IN[4] ^ sum[4];
                    flags_nxt[`CFO_B_V] = ~(OP_A_IN[7] ^ OP_B_IN[7]) &
                        (OP_A_IN[7] ^ sum[7]);
                    flags_nxt[`CFO_B_C] = sum[8];
                end
                `CFO_OP_SUB, `CFO_OP_SBC: begin
                    sum = add8(OP_A_IN, ~OP_B_IN,
                        ~((OP_CODE_IN == `CFO_OP_SBC) & flags_r[`CFO_B_C]));
                    res_nxt = sum[7:0];
                    flags_nxt[`CFO_B_V] = (OP_A_IN[7] ^ OP_B_IN[7]) &
                        (OP_A_IN[7] ^ sum[7]);
                    flags_nxt[`CFO_B_C] = ~sum[8];
                end
                `CFO_OP_AND: begin
                    res_nxt = OP_A_IN & OP_B_IN;
                    flags_nxt[`CFO_B_V] = 1'b0;
                end
                `CFO_OP_ORA: begin
                    res_nxt = OP_A_IN | OP_B_IN;
                    flags_nxt[`CFO_B_V] = 1'b0;
                end
                `CFO_OP_EOR: begin
                    res_nxt = OP_A_IN ^ OP_B_IN;
                    flags_nxt[`CFO_B_V] = 1'b0;
                end
                `CFO_OP_LD8: begin
                    res_nxt = OP_B_IN;
                    flags_nxt[`CFO_B_V] = 1'b0;
                end
                `CFO_OP_LD16: begin
                    res_nxt = OP_B_IN;
                    nz_upd = 1'b0;
                    flags_nxt[`CFO_B_V] = 1'b0;
                    flags_nxt[`CFO_B_N] = OP_A_IN[7];
                    flags_nxt[`CFO_B_Z] = ({OP_A_IN, OP_B_IN} == 16'h0000);
                end
                `CFO_OP_DADJ: begin
                    if (flags_r[`CFO_B_H] || OP_A_IN[3:0] > `CFO_BCD_NIB)
                        cor = cor | `CFO_BCD_LO;
                    if (flags_r[`CFO_B_C] || OP_A_IN > `CFO_BCD_BYTE)
                        cor = cor | `CFO_BCD_HI;
                    sum = add8(OP_A_IN, cor, 1'b0);
                    res_nxt = sum[7:0];
                    flags_nxt[`CFO_B_C] = cor[6];
                end
                `CFO_OP_ASL: begin
                    res_nxt = {OP_A_IN[6:0], 1'b0};
                    flags_nxt[`CFO_B_C] = OP_A_IN[7];
                    flags_nxt[`CFO_B_V] = OP_A_IN[7] ^ OP_A_IN[6];
                end
                `CFO_OP_LSR: begin
                    res_nxt = {1'b0, OP_A_IN[7:1]};
                    flags_nxt[`CFO_B_C] = OP_A_IN[0];
                    flags_nxt[`CFO_B_V] = OP_A_IN[0];
                end
                `CFO_OP_ROL: begin
                    res_nxt = {OP_A_IN[6:0], flags_r[`CFO_B_C]};
                    flags_nxt[`CFO_B_C] = OP_A_IN[7];
                    flags_nxt[`CFO_B_V] = OP_A_IN[7] ^ OP_A_IN[6];
                end
                `CFO_OP_BTST: begin
                    nz_upd = 1'b0;
                    flags_nxt[`CFO_B_C] = OP_A_IN[OP_B_IN[2:0]];
                end
                `CFO_OP_TAP: begin
                    nz_upd = 1'b0;
                    flags_nxt = OP_A_IN;
                    if (flags_r[`CFO_B_I] && !OP_A_IN[`CFO_B_I])
                        blk_nxt = 1'b1;
                end
                `CFO_OP_CLM: begin
                    nz_upd = 1'b0;
                    flags_nxt[`CFO_B_I] = 1'b0;
                    if (flags_r[`CFO_B_I])
                        blk_nxt = 1'b1;
                end
                default: nz_upd = 1'b0;
            endcase
            if (nz_upd) begin
                flags_nxt[`CFO_B_N] = res_nxt[7];
                flags_nxt[`CFO_B_Z] = (res_nxt == 8'h00);
            end
        end
        if (STACKED_IN)
            flags_nxt[`CFO_B_I] = 1'b1;
        flags_nxt = flags_nxt | `CFO_FIX1;
    end

    always @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            flags_r <= `CFO_FLAGS_RST;
            FLAGS_OUT <= `CFO_FLAGS_RST;
            RESULT_OUT <= 8'h00;
            blk_r <= 1'b0;
            LESS_OUT <= 1'b0;
            LESS_EQ_OUT <= 1'b0;
            INT_TAKE_OUT <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            FLAGS_OUT <= flags_nxt;
            RESULT_OUT <= res_nxt;
            blk_r <= blk_nxt;
            LESS_OUT <= flags_nxt[`CFO_B_N] ^ flags_nxt[`CFO_B_V];
            LESS_EQ_OUT <= flags_nxt[`CFO_B_Z] |
                (flags_nxt[`CFO_B_N] ^ flags_nxt[`CFO_B_V]);
            INT_TAKE_OUT <= BOUNDARY_IN & INT_REQ_IN &
                ~flags_r[`CFO_B_I] & ~blk_r;
        end
    end

    // ********************************************************
    // Operand fetch unit.
    // ********************************************************
    // Each request carries its own mode, so a move issues two
    // requests and may pick a different mode for each side.
    reg [2:0] st_r;
    reg [15:0] pc_r;
    reg [1:0] mode_r;
    reg cond_r;

    always @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            st_r <= S_IDLE;
            pc_r <= `CFO_PC_RST;
            mode_r <= `CFO_M_INHERENT;
            cond_r <= 1'b0;
            MEM_ADDR_OUT <= 16'h0000;
            MEM_RD_OUT <= 1'b0;
            OPND_OUT <= 16'h0000;
            DONE_OUT <= 1'b0;
            BUSY_OUT <= 1'b0;
        end else begin
            MEM_RD_OUT <= 1'b0;
            DONE_OUT <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    if (apb_wr && PADDR_IN == `CFO_A_PC)
                        pc_r <= PWDATA_IN[15:0];
                    if (FETCH_IN) begin
                        mode_r <= MODE_IN;
                        cond_r <= COND_IN;
                        if (MODE_IN == `CFO_M_INHERENT) begin
                            DONE_OUT <= 1'b1;
                        end else begin
                            MEM_ADDR_OUT <= pc_r;
                            MEM_RD_OUT <= 1'b1;
                            pc_r <= pc_r + 16'h0001;
                            BUSY_OUT <= 1'b1;
                            st_r <= S_RD1;
                        end
                    end
                end
                S_RD1: st_r <= S_CAP1;
                S_CAP1: begin
                    if (mode_r == `CFO_M_IMMED16) begin
                        OPND_OUT <= {MEM_RDATA_IN, 8'h00};
                        MEM_ADDR_OUT <= pc_r;
                        MEM_RD_OUT <= 1'b1;
                        pc_r <= pc_r + 16'h0001;
                        st_r <= S_RD2;
                    end else begin
                        if (mode_r == `CFO_M_RELATIVE) begin
                            OPND_OUT <= sext8(MEM_RDATA_IN);
                            if (cond_r)
                                pc_r <= pc_r + sext8(MEM_RDATA_IN);
                        end else begin
                            OPND_OUT <= {8'h00, MEM_RDATA_IN};
                        end
                        DONE_OUT <= 1'b1;
                        BUSY_OUT <= 1'b0;
                        st_r <= S_IDLE;
                    end
                end
                S_RD2: st_r <= S_CAP2;
                S_CAP2: begin
                    OPND_OUT <= {OPND_OUT[15:8], MEM_RDATA_IN};
                    DONE_OUT <= 1'b1;
                    BUSY_OUT <= 1'b0;
                    st_r <= S_IDLE;
                end
                default: begin
                    st_r <= S_IDLE;
                    BUSY_OUT <= 1'b0;
                end
            endcase
        end
    end

    // ********************************************************
    // APB slave.
    // ********************************************************
    // Read data is sampled in the setup cycle, so the access
    // phase always ends in its first cycle with no wait state.
    reg [31:0] rd_nxt;
    reg err_nxt;

    always @* begin
        rd_nxt = 32'h00000000;
        err_nxt = 1'b0;
        case (PADDR_IN)
            `CFO_A_FLAGS: rd_nxt = {24'h000000, flags_r};
            `CFO_A_PC: rd_nxt = {16'h0000, pc_r};
            `CFO_A_OPND: begin
                rd_nxt = {16'h0000, OPND_OUT};
                err_nxt = PWRITE_IN;
            end
            `CFO_A_STAT: begin
                rd_nxt = {22'h000000, blk_r, BUSY_OUT, RESULT_OUT};
                err_nxt = PWRITE_IN;
            end
            default: err_nxt = 1'b1;
        endcase
    end

    always @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            PRDATA_OUT <= 32'h00000000;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT <= apb_setup;
            PSLVERR_OUT <= apb_setup & err_nxt;
            if (apb_setup && !PWRITE_IN)
                PRDATA_OUT <= rd_nxt;
        end
    end

endmodule

// [dv/cfo_sva.sv]
`timescale 1ns/1ns
`include "cfo_map.vh"

// ********************************************************
// Flag, mask and fetch checks.
// ********************************************************
module cfo_sva (
    input wire CLK_IN,
    input wire RST_B_IN,
    input wire OP_VALID_IN,
    input wire [3:0] OP_CODE_IN,
    input wire [7:0] OP_A_IN,
    input wire [7:0] OP_B_IN,
    input wire [7:0] RESULT_OUT,
    input wire [7:0] FLAGS_OUT,
    input wire LESS_OUT,
    input wire LESS_EQ_OUT,
    input wire STACKED_IN,
    input wire BOUNDARY_IN,
    input wire INT_REQ_IN,
    input wire INT_TAKE_OUT,
    input wire FETCH_IN,
    input wire [1:0] MODE_IN,
    input wire COND_IN,
    input wire [15:0] MEM_ADDR_OUT,
    input wire MEM_RD_OUT,
    input wire [15:0] OPND_OUT,
    input wire DONE_OUT,
    input wire BUSY_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    wire [4:0] hsum = OP_A_IN[3:0] + OP_B_IN[3:0];
    wire [8:0] csum = OP_A_IN + OP_B_IN;
    wire add_op = OP_VALID_IN && OP_CODE_IN == `CFO_OP_ADD;
    wire nz_op = OP_VALID_IN && OP_CODE_IN < `CFO_OP_LD16;
    wire go = FETCH_IN && !BUSY_OUT;
    wire clm = OP_VALID_IN && OP_CODE_IN == `CFO_OP_CLM && FLAGS_OUT[3];

    AST_ONES: assert property (FLAGS_OUT[6:5] == 2'b11)
        else $error("Fixed flag bits not one.");
    AST_HALF: assert property (add_op |=> FLAGS_OUT[4] == $past(hsum[4]))
        else $error("Bad half carry.");
    AST_CARRY: assert property (add_op |=> FLAGS_OUT[0] == $past(csum[8]))
        else $error("Bad carry.");
    AST_NEG: assert property (nz_op |=> FLAGS_OUT[2] == RESULT_OUT[7])
        else $error("Bad negative flag.");
    AST_ZERO: assert property (nz_op |=> FLAGS_OUT[1] == (RESULT_OUT == 8'h00))
        else $error("Bad zero flag.");
    AST_LESS: assert property (OP_VALID_IN |=> LESS_OUT == (FLAGS_OUT[2] ^ FLAGS_OUT[7])
        && LESS_EQ_OUT == (FLAGS_OUT[1] | LESS_OUT)) else $error("Bad signed compare.");
    AST_MASK: assert property (BOUNDARY_IN && FLAGS_OUT[3] |=> !INT_TAKE_OUT)
        else $error("Interrupt taken while masked.");
    AST_STACK: assert property (STACKED_IN && !OP_VALID_IN |=> FLAGS_OUT[3])
        else $error("Mask not set after stacking.");
    AST_CLR: assert property (clm ##1 !BOUNDARY_IN ##1 BOUNDARY_IN |=> !INT_TAKE_OUT)
        else $error("Interrupt right after mask clear.");
    AST_INHERENT: assert property (go && MODE_IN == `CFO_M_INHERENT |=>
        DONE_OUT && !MEM_RD_OUT) else $error("Inherent fetch touched memory.");
    AST_IMMED8: assert property (go && MODE_IN == `CFO_M_IMMED8 |-> ##3 DONE_OUT
        && OPND_OUT[15:8] == 8'h00) else $error("Bad byte operand.");
    AST_WORD: assert property (go && MODE_IN == `CFO_M_IMMED16 |-> ##1 MEM_RD_OUT ##2
        MEM_RD_OUT && MEM_ADDR_OUT == $past(MEM_ADDR_OUT, 2) + 16'h0001)
        else $error("Bad word fetch order.");
    AST_RELATIVE: assert property (go && MODE_IN == `CFO_M_RELATIVE |-> ##3 DONE_OUT
        && OPND_OUT[15:8] == {8{OPND_OUT[7]}}) else $error("Offset not sign extended.");
    cover property (go && MODE_IN == `CFO_M_RELATIVE && COND_IN);
    cover property (BOUNDARY_IN && INT_REQ_IN ##1 INT_TAKE_OUT);
    cover property (clm ##1 !BOUNDARY_IN ##1 BOUNDARY_IN);
endmodule

bind cfo_core cfo_sva u_cfo_sva (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
    .OP_VALID_IN(OP_VALID_IN), .OP_CODE_IN(OP_CODE_IN), .OP_A_IN(OP_A_IN),
    .OP_B_IN(OP_B_IN), .RESULT_OUT(RESULT_OUT), .FLAGS_OUT(FLAGS_OUT), .LESS_OUT(LESS_OUT),
    .LESS_EQ_OUT(LESS_EQ_OUT), .STACKED_IN(STACKED_IN), .BOUNDARY_IN(BOUNDARY_IN),
    .INT_REQ_IN(INT_REQ_IN), .INT_TAKE_OUT(INT_TAKE_OUT), .FETCH_IN(FETCH_IN),
    .MODE_IN(MODE_IN), .COND_IN(COND_IN), .MEM_ADDR_OUT(MEM_ADDR_OUT),
    .MEM_RD_OUT(MEM_RD_OUT), .OPND_OUT(OPND_OUT), .DONE_OUT(DONE_OUT), .BUSY_OUT(BUSY_OUT));

// [dv/cfo_mem_model.sv]
`timescale 1ns/1ns

// ********************************************************
// Program memory answering byte reads.
// ********************************************************
module cfo_mem_model (
    input wire clk_in,
    input wire rst_b_in,
    input wire rd_in,
    input wire [15:0] addr_in,
    output reg [7:0] data_out
);
    reg [1:0] hold_r;
    // one flat space
    // Data holds for three cycles, then toggles so a late sample cannot pass by luck.
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            data_out <= 8'h5A;
            hold_r <= 2'h0;
        end else if (rd_in) begin
            data_out <= {addr_in[3:0], addr_in[7:4]} ^ addr_in[15:8] ^ 8'h3C;
            hold_r <= 2'h2;
        end else if (hold_r != 2'h0) begin
            hold_r <= hold_r - 2'h1;
        end else begin
            data_out <= ~data_out;
        end
    end
endmodule

// [dv/tb_cpu_flags_and_operand_modes.sv]
`timescale 1ns/1ns
`include "cfo_map.vh"

// ********************************************************
// Bench with reference model.
// ********************************************************
module tb_cpu_flags_and_operand_modes;
    reg clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, opv = 0, stk = 0;
    reg bnd = 0, ireq = 0, fet = 0, cnd = 0;
    reg [11:0] padr = 0;
    reg [31:0] pwd = 0, seed = 61436, q;
    reg [3:0] opc = 0;
    reg [7:0] opa = 0, opb = 0, mf;
    reg [1:0] mode = 0;
    reg e;
    wire [31:0] prd;
    wire prdy, perr, less, lesseq, itake, mrd, done, busy;
    wire [7:0] res, flg, mdat;
    wire [15:0] madr, opnd;
    integer mismatches = 0, comparisons = 0, cyc = 0, i, n;

    always #5 clk = ~clk;

    cfo_core u_cfo_core (.CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
        .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .OP_VALID_IN(opv), .OP_CODE_IN(opc),
        .OP_A_IN(opa), .OP_B_IN(opb), .RESULT_OUT(res), .FLAGS_OUT(flg), .LESS_OUT(less),
        .LESS_EQ_OUT(lesseq), .STACKED_IN(stk), .BOUNDARY_IN(bnd), .INT_REQ_IN(ireq),
        .INT_TAKE_OUT(itake), .FETCH_IN(fet), .MODE_IN(mode), .COND_IN(cnd),
        .MEM_ADDR_OUT(madr), .MEM_RD_OUT(mrd), .MEM_RDATA_IN(mdat), .OPND_OUT(opnd),
        .DONE_OUT(done), .BUSY_OUT(busy));
    cfo_mem_model u_cfo_mem_model (.clk_in(clk), .rst_b_in(rst_b), .rd_in(mrd),
        .addr_in(madr), .data_out(mdat));

    function automatic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction

    function automatic [7:0] mb(input [15:0] a);
        mb = {a[3:0], a[7:4]} ^ a[15:8] ^ 8'h3C;
    endfunction

    function automatic [15:0] model(input [3:0] o, input [7:0] a, b, f);
        reg [8:0] s;
        reg [7:0] r, g;
        reg c;
        begin
            g = f;
            r = a;
            c = o[0] & f[0];
            case (o)
                4'h0, 4'h1: begin
                    s = a + b + c;
                    r = s[7:0];
                    g[4] = a[3:0] + b[3:0] + c > 15;
                    g[0] = s[8];
                    g[7] = a[7] == b[7] && r[7] != a[7];
                end
                4'h2, 4'h3: begin
                    s = a - b - c;
                    r = s[7:0];
                    g[0] = s[8];
                    g[7] = a[7] != b[7] && r[7] != a[7];
                end
                4'h4: r = a & b;
                4'h5: r = a | b;
                4'h6: r = a ^ b;
                4'h7: r = b;
                4'h9: begin
                    c = f[0] | a > 8'h99;
                    r = a + (f[4] | a[3:0] > 4'h9 ? 8'h06 : 8'h00) + (c ? 8'h60 : 8'h00);
                    g[0] = c;
                end
                4'hA, 4'hC: begin
                    r = {a[6:0], o[2] & f[0]};
                    g[0] = a[7];
                    g[7] = a[7] ^ a[6];
                end
                4'hB: begin
                    r = a >> 1;
                    g[0] = a[0];
                    g[7] = a[0];
                end
                4'hD: g[0] = a[b[2:0]];
                4'hE: g = a | 8'h60;
                4'hF: g[3] = 1'b0;
                default: g[7] = 1'b0;
            endcase
            if (o < 4'hD) g[2] = r[7];
            if (o < 4'hD) g[1] = r == 8'h00;
            if (o >= 4'h4 && o <= 4'h8) g[7] = 1'b0;
            if (o == 4'h8) g[2] = a[7];
            if (o == 4'h8) g[1] = {a, b} == 16'h0000;
            model = {r, g};
        end
    endfunction

    task chk(input string nm, input [31:0] s, x);
        comparisons = comparisons + 1;
        if (s !== x) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask

    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // The request is held until the edge that sees the ready pulse.
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk) pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        q = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task alu(input [3:0] o, input [7:0] a, b);
        reg [15:0] x;
        begin
            x = model(o, a, b, mf);
            @(posedge clk);
            opv <= 1'b1;
            opc <= o;
            opa <= a;
            opb <= b;
            @(posedge clk) opv <= 1'b0;
            #1 mf = x[7:0];
            if (o < 4'hD && o != 4'h8) chk("result", res, x[15:8]);
            chk("flags", flg, mf);
            chk("less_eq", {less, lesseq}, {mf[2] ^ mf[7], mf[1] | mf[2] ^ mf[7]});
        end
    endtask

    task bound(input x);
        @(posedge clk) bnd <= 1'b1;
        @(posedge clk) bnd <= 1'b0;
        #1 chk("int_take", itake, x);
    endtask

    task fetch(input [1:0] m, input c, input [15:0] pc);
        reg [15:0] x, p;
        begin
            apb(1'b1, `CFO_A_PC, {16'h0000, pc});
            @(posedge clk);
            fet <= 1'b1;
            mode <= m;
            cnd <= c;
            @(posedge clk) fet <= 1'b0;
            #1 i = 0;
            while (done !== 1'b1 && i < 20) @(posedge clk) #1 i = i + 1;
            chk("done", done, 1'b1);
            x = {8'h00, mb(pc)};
            p = pc + 16'h0001;
            if (m == `CFO_M_INHERENT) p = pc;
            if (m == `CFO_M_IMMED16) x = {mb(pc), mb(pc + 16'h0001)};
            if (m == `CFO_M_IMMED16) p = pc + 16'h0002;
            if (m == `CFO_M_RELATIVE) x = {{8{x[7]}}, x[7:0]};
            if (m == `CFO_M_RELATIVE && c) p = p + x;
            if (m != `CFO_M_INHERENT) chk("operand", opnd, x);
            apb(1'b0, `CFO_A_PC, 32'h0);
            chk("pc", q, p);
        end
    endtask

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc > 5000) begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        #1 chk("flags_reset", flg, `CFO_FLAGS_RST);
        apb(1'b0, `CFO_A_FLAGS, 32'h0);
        chk("flags_read", q, `CFO_FLAGS_RST);
        apb(1'b1, `CFO_A_FLAGS, 32'h0);
        apb(1'b0, `CFO_A_FLAGS, 32'h0);
        chk("flags_fixed", q, 32'h60);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", e, 1'b1);
        apb(1'b1, `CFO_A_OPND, 32'h5);
        chk("read_only", e, 1'b1);
        mf = 8'h60;
        for (n = 0; n < 96; n = n + 1) begin
            q = rnd();
            alu(n[3:0], q[7:0], q[15:8]);
        end
        ireq <= 1'b1;
        apb(1'b1, `CFO_A_FLAGS, 32'h08);
        mf = 8'h68;
        bound(1'b0);
        alu(`CFO_OP_CLM, 8'h00, 8'h00);
        bound(1'b0);
        bound(1'b1);
        @(posedge clk) stk <= 1'b1;
        @(posedge clk) stk <= 1'b0;
        #1 chk("mask_set", flg[3], 1'b1);
        mf[3] = 1'b1;
        alu(`CFO_OP_TAP, 8'h00, 8'h00);
        bound(1'b0);
        bound(1'b1);
        ireq <= 1'b0;
        for (n = 0; n < 16; n = n + 1) begin
            q = rnd();
            fetch(n[1:0], q[16], q[15:0]);
        end
        report_and_stop;
    end
endmodule
